// >>> afc_pkg.sv
// Purpose: shared constants for the strobed fifo host controller
// Assumes: 40 MHz system clock, AHB-Lite register access, 32-bit data
// Notes: pin times are plain defaults in ns, cycle counts derived below
package afc_pkg;
    // clock rate used to turn times into cycles
    localparam int CLK_MHZ = 40;
    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] WDATA_OFS = 8'h04;
    localparam logic [7:0] RDATA_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;
    localparam logic [7:0] CFG_OFS = 8'h10;
    // control bits (write one to start)
    localparam int CTRL_INIT_BIT = 0;
    localparam int CTRL_PUSH_BIT = 1;
    localparam int CTRL_POP_BIT = 2;
    localparam int CTRL_REPLAY_BIT = 3;
    localparam int CTRL_CLR_BIT = 4;
    // config bits
    localparam int CFG_CHAIN_BIT = 0;
    localparam int CFG_HEAD_BIT = 1;
    // status bits
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_INITD_BIT = 1;
    localparam int ST_ENTRIES_BIT = 2;
    localparam int ST_SPACE_BIT = 3;
    localparam int ST_HALF_BIT = 4;
    localparam int ST_PUSH_REF_BIT = 5;
    localparam int ST_POP_REF_BIT = 6;
    localparam int ST_REPLAY_REF_BIT = 7;
    localparam int ST_STALE_BIT = 8;
    // reset values
    localparam logic [1:0] CFG_RST = 2'h0;
    localparam logic [8:0] DATA_RST = 9'h000;
    // pin times in ns
    localparam int INIT_PULSE_TIME_NS = 35;
    localparam int INIT_SETUP_TIME_NS = 10;
    localparam int INIT_RECOVERY_TIME_NS = 10;
    localparam int STROBE_PULSE_TIME_NS = 35;
    localparam int POP_TO_SPACE_DELAY_NS = 30;
    localparam int PUSH_TO_ENTRIES_DELAY_NS = 30;
    // least times round up; two extra cycles cover the input synchroniser
    localparam int SYNC_CYC = 2;
    localparam int INIT_LOW_CYC = ((INIT_PULSE_TIME_NS > INIT_SETUP_TIME_NS ?
        INIT_PULSE_TIME_NS : INIT_SETUP_TIME_NS) * CLK_MHZ + 999) / 1000;
    localparam int INIT_REC_CYC = (INIT_RECOVERY_TIME_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
    localparam int PUSH_LOW_CYC = (STROBE_PULSE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int POP_LOW_CYC = (STROBE_PULSE_TIME_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
    localparam int PUSH_SETTLE_CYC = (PUSH_TO_ENTRIES_DELAY_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
    localparam int POP_SETTLE_CYC = (POP_TO_SPACE_DELAY_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC;
    localparam int REPLAY_LOW_CYC = PUSH_LOW_CYC;
    localparam int REPLAY_REC_CYC = INIT_REC_CYC;
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_INIT_LO = 3'b001,
        ST_PUSH_LO = 3'b010,
        ST_POP_LO = 3'b011,
        ST_REPLAY_LO = 3'b100,
        ST_SETTLE = 3'b101
    } afc_state_type;
endpackage

// >>> afc_host.sv
// Purpose: host controller driving a strobed 9-bit fifo through its pins
// Assumes: software reaches command/status registers over AHB-Lite
// Notes: one operation at a time; commands other than clear are ignored while busy
// Behaviour
// - apply init before any push
// - strobes high around init rise
// - push only when no-space flag released
// - pop only when no-entries flag released
// - strobes high during any replay pulse
// - replay valid only below depth pushes; the host does not refuse later replays, it only sets the stale status bit
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module afc_host
    import afc_pkg::*;
#(
    parameter int DEPTH = 512 // fifo depth, one of the six sizes
) (
    input wire logic sys_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic ce, // clock enable, freezes all state when low
    input wire logic hsel, // ahb slave select
    input wire logic [31:0] haddr, // ahb address
    input wire logic [1:0] htrans, // ahb transfer type
    input wire logic hwrite, // ahb write
    input wire logic [2:0] hsize, // ahb size, word only
    input wire logic [31:0] hwdata, // ahb write data
    input wire logic hready, // ahb bus ready
    output logic hreadyout, // ahb slave ready
    output logic hresp, // ahb response, always okay
    output logic [31:0] hrdata, // ahb read data
    output logic init_pulse_n, // fifo init, active low
    output logic push_n, // fifo push strobe, active low
    output logic pop_n, // fifo pop strobe, active low
    output logic head_sel_replay_n, // head select or replay request
    output logic chain_in_n, // fifo chain input, low for single mode
    output logic [8:0] in_bus, // data toward the fifo
    input wire logic [8:0] out_bus, // data from the fifo (resolved level)
    input wire logic no_space_n, // fifo full flag, active low
    input wire logic no_entries_n, // fifo empty flag, active low
    input wire logic chain_out_half_level_n // half level or chain pulse
);
    localparam int CW = 8; // width of the interval counter
    localparam int PCW = $clog2(DEPTH) + 1; // push counter width

    afc_state_type state_r; // sequencer state
    logic [CW-1:0] cnt_r; // cycles left in current interval
    logic [11:0] flag_s1_r, flag_s2_r; // two-stage pin synchroniser
    logic init_done_r; // init pulse completed
    logic [1:0] cfg_r; // chain mode and head device bits
    logic [8:0] wdata_r; // word to push
    logic [8:0] rdata_r; // last popped word
    logic push_ref_r, pop_ref_r, replay_ref_r; // sticky refusal flags
    logic [PCW-1:0] push_cnt_r; // pushes since init, saturating
    logic replay_n_r; // replay strobe level
    logic wr_pend_r; // write data phase pending
    logic [7:0] wr_ofs_r; // offset of pending write
    logic hresp_r, hready_r; // registered bus answers
    logic [31:0] status; // status word
    logic do_ctrl; // data-phase write to control
    logic take_init, take_push, take_pop, take_replay, take_clr; // command pulses
    logic push_ok, pop_ok, replay_ok; // command accepted this cycle
    logic [8:0] bus_s; // synchronised data bus
    logic space_s, entries_s, half_s; // synchronised flags

    // word-aligned offset decode shared by read and write paths
    function automatic logic [7:0] ofs_of(input logic [31:0] a);
        ofs_of = {a[7:2], 2'b00};
    endfunction

    assign bus_s = flag_s2_r[8:0];
    assign entries_s = flag_s2_r[9];
    assign space_s = flag_s2_r[10];
    assign half_s = flag_s2_r[11];

    // every pin input passes two flops before use
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flag_s1_r <= 12'h000;
            flag_s2_r <= 12'h000;
        end else if (ce) begin
            flag_s1_r <= {chain_out_half_level_n, no_space_n, no_entries_n, out_bus};
            flag_s2_r <= flag_s1_r;
        end
    end

    // status word, unused bits read zero
    always_comb begin
        status = 32'h0;
        status[ST_BUSY_BIT] = (state_r != ST_IDLE);
        status[ST_INITD_BIT] = init_done_r;
        status[ST_ENTRIES_BIT] = entries_s;
        status[ST_SPACE_BIT] = space_s;
        status[ST_HALF_BIT] = half_s;
        status[ST_PUSH_REF_BIT] = push_ref_r;
        status[ST_POP_REF_BIT] = pop_ref_r;
        status[ST_REPLAY_REF_BIT] = replay_ref_r;
        status[ST_STALE_BIT] = (push_cnt_r >= PCW'(DEPTH));
    end

    // command decode: pulses only in the data phase of a control write
    assign do_ctrl = ce && wr_pend_r && (wr_ofs_r == CTRL_OFS);
    assign take_init = do_ctrl && hwdata[CTRL_INIT_BIT] && (state_r == ST_IDLE);
    assign take_push = do_ctrl && hwdata[CTRL_PUSH_BIT] && (state_r == ST_IDLE);
    assign take_pop = do_ctrl && hwdata[CTRL_POP_BIT] && (state_r == ST_IDLE);
    assign take_replay = do_ctrl && hwdata[CTRL_REPLAY_BIT] && (state_r == ST_IDLE);
    assign take_clr = do_ctrl && hwdata[CTRL_CLR_BIT];
    // init wins over push, pop and replay written alongside it; a clear still takes effect
    assign push_ok = take_push && !take_init && init_done_r && space_s;
    assign pop_ok = take_pop && !take_init && !take_push && init_done_r && entries_s;
    // replay only in single mode, with strobes idle
    assign replay_ok = take_replay && !take_init && !take_push && !take_pop
        && init_done_r && !cfg_r[CFG_CHAIN_BIT];

    // ahb slave: zero wait states, read data loaded during address phase
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_r <= 1'b0;
            wr_ofs_r <= 8'h00;
            hrdata <= 32'h0;
            hresp_r <= 1'b0;
            hready_r <= 1'b1;
        end else if (ce) begin
            wr_pend_r <= hsel && htrans[1] && hready && hwrite;
            wr_ofs_r <= ofs_of(haddr);
            if (hsel && htrans[1] && hready && !hwrite) begin
                case (ofs_of(haddr))
                    WDATA_OFS: hrdata <= {23'h0, wdata_r};
                    RDATA_OFS: hrdata <= {23'h0, rdata_r};
                    STAT_OFS: hrdata <= status;
                    CFG_OFS: hrdata <= {30'h0, cfg_r};
                    default: hrdata <= 32'h0; // control and unmapped read zero
                endcase
            end
        end
    end
    assign hresp = hresp_r;
    assign hreadyout = hready_r;

    // software-written data and configuration
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            wdata_r <= DATA_RST;
            cfg_r <= CFG_RST;
        end else if (ce && wr_pend_r) begin
            if (wr_ofs_r == WDATA_OFS) begin
                wdata_r <= hwdata[8:0];
            end
            // mode change is only safe between operations
            if (wr_ofs_r == CFG_OFS && state_r == ST_IDLE) begin
                cfg_r <= hwdata[1:0];
            end
        end
    end

    // sticky refusals: a new refusal wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            push_ref_r <= 1'b0;
            pop_ref_r <= 1'b0;
            replay_ref_r <= 1'b0;
        end else if (ce) begin
            if (take_push && !take_init && !push_ok) begin
                push_ref_r <= 1'b1;
            end else if (take_clr) begin
                push_ref_r <= 1'b0;
            end
            if (take_pop && !take_init && !take_push && !pop_ok) begin
                pop_ref_r <= 1'b1;
            end else if (take_clr) begin
                pop_ref_r <= 1'b0;
            end
            if (take_replay && !take_init && !take_push && !take_pop && !replay_ok) begin
                replay_ref_r <= 1'b1;
            end else if (take_clr) begin
                replay_ref_r <= 1'b0;
            end
        end
    end

    // pushes since init, so software can tell replayed data is stale
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            push_cnt_r <= '0;
        end else if (ce) begin
            if (take_init) begin
                push_cnt_r <= '0;
            end else if (push_ok && push_cnt_r < PCW'(DEPTH)) begin
                push_cnt_r <= push_cnt_r + 1'b1;
            end
        end
    end

    // pin sequencer: one strobe at a time, each held then settled
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            cnt_r <= '0;
            init_pulse_n <= 1'b1;
            push_n <= 1'b1;
            pop_n <= 1'b1;
            replay_n_r <= 1'b1;
            init_done_r <= 1'b0;
            in_bus <= DATA_RST;
            rdata_r <= DATA_RST;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    // strobes already high here, so init setup is met
                    if (take_init) begin
                        init_pulse_n <= 1'b0;
                        init_done_r <= 1'b0;
                        cnt_r <= CW'(INIT_LOW_CYC - 1);
                        state_r <= ST_INIT_LO;
                    end else if (push_ok) begin
                        push_n <= 1'b0;
                        in_bus <= wdata_r;
                        cnt_r <= CW'(PUSH_LOW_CYC - 1);
                        state_r <= ST_PUSH_LO;
                    end else if (pop_ok) begin
                        pop_n <= 1'b0;
                        cnt_r <= CW'(POP_LOW_CYC - 1);
                        state_r <= ST_POP_LO;
                    end else if (replay_ok) begin
                        replay_n_r <= 1'b0;
                        cnt_r <= CW'(REPLAY_LOW_CYC - 1);
                        state_r <= ST_REPLAY_LO;
                    end
                end
                ST_INIT_LO: begin
                    if (cnt_r == '0) begin
                        init_pulse_n <= 1'b1;
                        init_done_r <= 1'b1;
                        // strobes stay high through recovery and flag settling
                        cnt_r <= CW'(INIT_REC_CYC - 1);
                        state_r <= ST_SETTLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_PUSH_LO: begin
                    if (cnt_r == '0) begin
                        push_n <= 1'b1; // word captured on this rise
                        cnt_r <= CW'(PUSH_SETTLE_CYC - 1);
                        state_r <= ST_SETTLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_POP_LO: begin
                    if (cnt_r == '0) begin
                        rdata_r <= bus_s; // bus only driven while pop low
                        pop_n <= 1'b1;
                        cnt_r <= CW'(POP_SETTLE_CYC - 1);
                        state_r <= ST_SETTLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_REPLAY_LO: begin
                    if (cnt_r == '0) begin
                        replay_n_r <= 1'b1;
                        cnt_r <= CW'(REPLAY_REC_CYC - 1);
                        state_r <= ST_SETTLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                ST_SETTLE: begin
                    // flags need their delay plus synchroniser before reuse
                    if (cnt_r == '0) begin
                        state_r <= ST_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 1'b1;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // mode pins: grounded chain input selects single mode
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            chain_in_n <= 1'b0;
            head_sel_replay_n <= 1'b1;
        end else if (ce) begin
            chain_in_n <= cfg_r[CFG_CHAIN_BIT];
            // head device grounds the shared pin; single mode sends replay on it
            head_sel_replay_n <= cfg_r[CFG_CHAIN_BIT] ? !cfg_r[CFG_HEAD_BIT]
                : (replay_n_r && !(state_r == ST_IDLE && replay_ok));
        end
    end
endmodule
`default_nettype wire

// >>> afc_host_checker.sv
// Purpose: pin-level checks of the strobed fifo host controller
// Assumes: one clock domain, async active-low reset
// Notes: flags reach the host two flops late, hence the deep past below
`timescale 1ns/1ps
`default_nettype none
module afc_host_checker (
    input wire logic sys_clk, // system clock
    input wire logic nrst, // async reset, active low
    input wire logic init_pulse_n, // fifo init
    input wire logic push_n, // push strobe
    input wire logic pop_n, // pop strobe
    input wire logic head_sel_replay_n, // head select or replay
    input wire logic chain_in_n, // chain input
    input wire logic [8:0] in_bus, // push data
    input wire logic no_space_n, // full flag
    input wire logic no_entries_n // empty flag
);
    logic inited_r; // an init has been issued
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // remember the first init so an early push stands out
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            inited_r <= 1'b0;
        end else if (!init_pulse_n) begin
            inited_r <= 1'b1;
        end
    end
    init_width_a: assert property ($fell(init_pulse_n) |-> !init_pulse_n[*2] ##1 init_pulse_n)
        else $error("init pulse width wrong");
    init_quiet_a: assert property ($rose(init_pulse_n) |-> (push_n && pop_n)[*3])
        else $error("strobe moved around init rise");
    push_first_a: assert property ($fell(push_n) |-> inited_r)
        else $error("push before any init");
    push_width_a: assert property ($fell(push_n) |-> !push_n[*2] ##1 push_n)
        else $error("push strobe width wrong");
    push_data_a: assert property ($fell(push_n) |=> $stable(in_bus)[*2])
        else $error("push data moved during strobe");
    push_guard_a: assert property ($fell(push_n) |-> $past(no_space_n, 3))
        else $error("push started while full");
    pop_width_a: assert property ($fell(pop_n) |-> !pop_n[*4] ##1 pop_n)
        else $error("pop strobe width wrong");
    pop_guard_a: assert property ($fell(pop_n) |-> $past(no_entries_n, 3))
        else $error("pop started while empty");
    one_strobe_a: assert property ((!push_n || !pop_n) |->
        (push_n || pop_n) && init_pulse_n && (head_sel_replay_n || chain_in_n))
        else $error("strobes overlap");
    // the shared pin falls with the replay flop but rises one cycle after it, so it stands low three cycles
    replay_width_a: assert property ($fell(head_sel_replay_n) && !chain_in_n |->
        !head_sel_replay_n[*3] ##1 head_sel_replay_n)
        else $error("replay pulse width wrong");
endmodule
bind afc_host afc_host_checker i_afc_host_checker (.sys_clk(sys_clk), .nrst(nrst),
    .init_pulse_n(init_pulse_n), .push_n(push_n), .pop_n(pop_n),
    .head_sel_replay_n(head_sel_replay_n), .chain_in_n(chain_in_n), .in_bus(in_bus),
    .no_space_n(no_space_n), .no_entries_n(no_entries_n));
`default_nettype wire

// >>> afc_fifo_model.sv
// Purpose: behavioural strobed 9-bit fifo standing at the host's far side
// Assumes: no pop-then-push wrap between replays, single device only
// Notes: an idle bus shows the inverse of the last word, never a held value
`timescale 1ns/1ps
`default_nettype none
module afc_fifo_model #(
    parameter int DEPTH = 512 // storage words
) (
    input wire logic init_pulse_n, // init, active low
    input wire logic push_n, // push strobe
    input wire logic pop_n, // pop strobe
    input wire logic head_sel_replay_n, // head select or replay
    input wire logic chain_in_n, // low selects single mode
    input wire logic [8:0] in_bus, // push data
    output logic [8:0] out_bus, // pop data
    output logic no_space_n, // full flag
    output logic no_entries_n, // empty flag
    output logic chain_out_half_level_n, // half level or chain pulse
    output int misuse // host slips seen
);
    logic [8:0] mem [DEPTH]; // storage
    int rd_ptr, wr_ptr, fill; // ring pointers and occupancy
    logic half_n, push_on, pop_on, inited; // internal state
    initial begin
        {rd_ptr, wr_ptr, fill, misuse} = '0;
        {half_n, push_on, pop_on, inited} = 4'h8;
        out_bus = 9'h000;
    end
    assign #10 no_space_n = (fill != DEPTH);
    assign #10 no_entries_n = (fill != 0);
    assign chain_out_half_level_n = chain_in_n ? !(push_on && wr_ptr == DEPTH - 1) : half_n;
    // pointers home while init is low
    always @(negedge init_pulse_n) begin
        {rd_ptr, wr_ptr, fill} = '0;
        half_n = 1'b1;
        inited = 1'b1;
    end
    // strobes must stand high over an init rise or a replay
    always @(posedge init_pulse_n or negedge head_sel_replay_n)
        if (inited && !(push_n && pop_n)) misuse++;
    always @(negedge push_n) begin
        if (!inited) misuse++;
        push_on = no_space_n && init_pulse_n;
        if (push_on && fill >= DEPTH / 2) half_n = 1'b0;
    end
    // word lands on the rising strobe
    always @(posedge push_n) if (push_on) begin
        mem[wr_ptr] = in_bus;
        wr_ptr = (wr_ptr + 1) % DEPTH;
        fill++;
        push_on = 1'b0;
    end
    always @(negedge pop_n) begin
        pop_on = no_entries_n && init_pulse_n;
        if (pop_on) out_bus <= #15 mem[rd_ptr];
    end
    always @(posedge pop_n) begin
        out_bus <= #5 ~out_bus;
        if (pop_on) begin
            rd_ptr = (rd_ptr + 1) % DEPTH;
            fill--;
            if (fill <= DEPTH / 2) half_n = 1'b1;
            pop_on = 1'b0;
        end
    end
    // replay only in single mode; fill stays right while writes have not wrapped
    always @(negedge head_sel_replay_n) if (!chain_in_n && inited && init_pulse_n) begin
        rd_ptr = 0;
        fill = wr_ptr;
        half_n = !(fill > DEPTH / 2);
    end
endmodule
`default_nettype wire

// >>> afc_host_tb.sv
// Purpose: self-checking bench of the fifo host over AHB-Lite
// Assumes: one slave, so its ready is the bus ready
// Notes: every wait is bounded and a spent bound ends the run
`timescale 1ns/1ps
`default_nettype none
module afc_host_tb;
    import afc_pkg::*;
    localparam int D = 512; // fifo depth under test
    logic sys_clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic hreadyout, hresp, init_pulse_n, push_n, pop_n, head_sel_replay_n, chain_in_n;
    logic no_space_n, no_entries_n, chain_out_half_level_n;
    logic [8:0] in_bus, out_bus;
    logic [13:0] pins; // host pins packed for one compare
    int misuse, failures = 0, comparisons = 0;
    assign pins = {init_pulse_n, push_n, pop_n, head_sel_replay_n, chain_in_n, in_bus};
    always #12.5 sys_clk = ~sys_clk;
    afc_host #(.DEPTH(D)) i_afc_host (.sys_clk(sys_clk), .nrst(nrst), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .init_pulse_n(init_pulse_n), .push_n(push_n), .pop_n(pop_n),
        .head_sel_replay_n(head_sel_replay_n), .chain_in_n(chain_in_n), .in_bus(in_bus),
        .out_bus(out_bus), .no_space_n(no_space_n), .no_entries_n(no_entries_n),
        .chain_out_half_level_n(chain_out_half_level_n));
    afc_fifo_model #(.DEPTH(D)) i_afc_fifo_model (.init_pulse_n(init_pulse_n),
        .push_n(push_n), .pop_n(pop_n), .head_sel_replay_n(head_sel_replay_n),
        .chain_in_n(chain_in_n), .in_bus(in_bus), .out_bus(out_bus),
        .no_space_n(no_space_n), .no_entries_n(no_entries_n),
        .chain_out_half_level_n(chain_out_half_level_n), .misuse(misuse));
    task automatic complete_run();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one bus phase: wait for the edge that samples ready high
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            failures++;
            complete_run();
        end
    endtask
    // single word transfer; read data is taken at the data-phase edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        edge_ready();
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic st_chk(input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] s;
        bus(1'b0, STAT_OFS, 32'h0, s);
        chk(s & mask, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    // issue a command, then poll busy under a bound
    task automatic cmd(input logic [31:0] c);
        logic [31:0] s;
        int n;
        wr(CTRL_OFS, c);
        n = 0;
        do begin
            bus(1'b0, STAT_OFS, 32'h0, s);
            n++;
        end while (s[ST_BUSY_BIT] !== 1'b0 && n < 40);
        if (s[ST_BUSY_BIT] !== 1'b0) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic push(input logic [8:0] w);
        wr(WDATA_OFS, {23'h0, w});
        cmd(32'h2);
    endtask
    task automatic pop_chk(input logic [8:0] w);
        logic [31:0] x;
        cmd(32'h4);
        bus(1'b0, RDATA_OFS, 32'h0, x);
        chk(x, {23'h0, w});
    endtask
    // pins are looked at mid-cycle, once the config flops have landed
    task automatic pin_chk(input logic [13:0] exp);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk({18'h0, pins}, {18'h0, exp});
        @(posedge sys_clk);
    endtask
    // idle pins, refusals before init, register map corners
    task automatic t_early();
        logic [31:0] x;
        pin_chk(14'h3c00);
        cmd(32'h2);
        cmd(32'h4);
        cmd(32'h8);
        st_chk(32'he2, 32'he0);
        cmd(32'h10);
        st_chk(32'he0, 32'h0);
        wr(8'h14, 32'h1ff);
        wr(RDATA_OFS, 32'h1ff);
        bus(1'b0, 8'h14, 32'h0, x);
        chk(x, 32'h0);
        bus(1'b0, RDATA_OFS, 32'h0, x);
        chk(x, {23'h0, DATA_RST});
        bus(1'b0, CTRL_OFS, 32'h0, x);
        chk(x, 32'h0);
        $display("test early done");
    endtask
    // order of words and the empty boundary
    task automatic t_order();
        cmd(32'h1);
        st_chk(32'h1ff, 32'h1a);
        push(9'h1ff);
        push(9'h000);
        push(9'h155);
        st_chk(32'h1c, 32'h1c);
        pop_chk(9'h1ff);
        pop_chk(9'h000);
        pop_chk(9'h155);
        cmd(32'h4);
        st_chk(32'h5c, 32'h58);
        cmd(32'h10);
        $display("test order done");
    endtask
    // fill to full, one refused push, drain with half-level tracking
    task automatic t_fill();
        cmd(32'h1);
        for (int k = 1; k <= D; k++) begin
            push(k[8:0]);
            st_chk(32'h1c, 32'h4 | (k < D ? 32'h8 : 0) | (k <= D / 2 ? 32'h10 : 0));
        end
        push(9'h0aa);
        st_chk(32'h13c, 32'h124);
        for (int k = 1; k <= D; k++) begin
            pop_chk(k[8:0]);
            st_chk(32'h1c, (k < D ? 32'h4 : 0) | 32'h8 | (D - k <= D / 2 ? 32'h10 : 0));
        end
        cmd(32'h10);
        $display("test fill done");
    endtask
    // rewind in single mode, refusal and head select in chain mode
    task automatic t_replay();
        cmd(32'h1);
        push(9'h101);
        push(9'h102);
        push(9'h103);
        pop_chk(9'h101);
        pop_chk(9'h102);
        cmd(32'h8);
        st_chk(32'h9c, 32'h1c);
        pop_chk(9'h101);
        pop_chk(9'h102);
        pop_chk(9'h103);
        wr(CFG_OFS, 32'h1);
        pin_chk({5'h1f, 9'h103});
        cmd(32'h8);
        st_chk(32'h80, 32'h80);
        wr(CFG_OFS, 32'h3);
        pin_chk({5'h1d, 9'h103});
        wr(CFG_OFS, 32'h1);
        wr(CFG_OFS, 32'h0);
        pin_chk({5'h1e, 9'h103});
        cmd(32'h10);
        $display("test replay done");
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        t_early();
        t_order();
        t_fill();
        t_replay();
        chk(misuse, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
